// File: core/acr_pkg.sv
// Shared constants and types for the converter serial interface block
package acr_pkg;

    localparam int ACR_RES_W      = 14;
    localparam int ACR_CFG_W      = 14;
    localparam int ACR_FRAME_W    = ACR_RES_W + ACR_CFG_W;

    // Conversion time and its cycle count at the system clock
    localparam int ACR_CLK_PERIOD_NS = 40;
    localparam int ACR_CONV_TIME_NS  = 2200;
    localparam int ACR_CONV_CYCLES_RAW = ACR_CONV_TIME_NS / ACR_CLK_PERIOD_NS;
    localparam int ACR_CONV_CYCLES = (ACR_CONV_CYCLES_RAW < 1) ? 1 : ACR_CONV_CYCLES_RAW;
    localparam int ACR_TIMER_W     = 8;

    // Falling serial clock edges until the data output is released; ACR_FALL_MAX caps the edge count
    localparam logic [4:0] ACR_REL_PLAIN    = 5'h0e;
    localparam logic [4:0] ACR_REL_PLAIN_RB = 5'h1c;
    localparam logic [4:0] ACR_REL_BUSY     = 5'h0f;
    localparam logic [4:0] ACR_REL_BUSY_RB  = 5'h1d;
    localparam logic [4:0] ACR_FALL_MAX     = 5'h1f;

    // Count, from 0, of the last of the 14 rising edges that make up one configuration word
    localparam logic [3:0] ACR_CFG_LAST_EDGE = 4'hd;

    // Configuration field: readback disable, 1 means no readback
    localparam int ACR_CFG_NO_RB_BIT = 0;
    localparam logic [ACR_CFG_W-1:0] ACR_CFG_RESET = 14'h3fff;

    typedef enum logic [0:0] {
        ACR_IDLE,
        ACR_CONVERT
    } acr_state_t;

endpackage

// File: core/acr_sync.sv
// Two-stage level synchroniser, one per bit
`timescale 1ns/1ps
`default_nettype none

module acr_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             clkEn,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_r;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1_r <= '0;
            syncOut  <= '0;
        end else if (clkEn) begin
            stage1_r <= asyncIn;
            syncOut  <= stage1_r;
        end
    end

endmodule

`default_nettype wire

// File: core/acr_serial_convert.sv
// Convert strobe handling, conversion timing and serial config/result transfer
`timescale 1ns/1ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Strobe rising edge starts conversion, floats data output, ignores config input.
// - A started conversion completes regardless of later strobe level.
// - Plain mode: strobe low after conversion drives the result MSB out.
// - Host sends config MSB first; device samples first 14 rising edges.
// - Plain mode: first 13 falling edges shift remaining bits, from MSB-1.
// - Busy mode: first 14 falling edges shift result out, MSB first.
// - Config word applies only when all 14 bits arrived; shorter is dropped.
// - Output data changes on falling edges and holds across rising edges.
// - Plain mode: release after 14th (28th readback) falling edge or strobe rise.
// - Readback: config word follows result LSB, MSB first, plain mode release after 28.
// - Plain mode: result LSB by 13th falling edge, config LSB by 27th.
// - Busy mode: at conversion end output goes from floating to low.
// - Busy mode: release on 15th falling edge, 29th with readback.
// - Busy mode readback sends config after result, 29 edges to release.
// - Busy mode without releasing edge, last bit held until busy goes low.
// - New config takes effect only at first conversion end after writing.
// - Config not complete before conversion end is not applied then.
module acr_serial_convert
    import acr_pkg::*;
#(
    parameter int                   CONV_CYCLES = ACR_CONV_CYCLES,
    parameter logic [ACR_CFG_W-1:0] CFG_RESET   = ACR_CFG_RESET
) (
    input  wire logic                 ref_clk,
    input  wire logic                 reset_n,
    input  wire logic                 clkEn,
    input  wire logic                 serialClk,
    input  wire logic                 convertStrobe,
    input  wire logic                 serialCfgIn,
    output logic                      serialResultOut,
    output logic                      serialResultOutEn,
    output logic                      convStart,
    output logic                      convEnd,
    output logic [ACR_CFG_W-1:0]      activeCfg,
    input  wire logic [ACR_RES_W-1:0] sampleResult
);

    //////////////////////////////////////////////////////////////////////////////////////
    // Declarations

    acr_state_t                 state_r;
    logic [ACR_TIMER_W-1:0]     convTimer_r;
    logic                       strobePrev_r;
    logic                       strobeSync;
    logic                       cfgTglSync;
    logic                       cfgTglSeen_r;
    logic                       releasedSync;
    logic                       convDone;
    logic                       startEvt;
    logic                       cfgEvt;

    logic [ACR_RES_W-1:0]       resultWord_r;
    logic [ACR_CFG_W-1:0]       resultCfg_r;
    logic [ACR_CFG_W-1:0]       pendingCfg_r;
    logic                       pendingValid_r;
    logic                       busyMode_r;
    logic                       dataReady_r;
    logic                       holdLast_r;
    logic                       lastBit_r;

    logic                       linkRst;
    logic [3:0]                 riseCnt_r;
    logic                       cfgFull_r;
    logic [ACR_CFG_W-2:0]       cfgShift_r;
    logic [ACR_CFG_W-1:0]       cfgHold_r;
    logic                       cfgTgl_r;
    logic [4:0]                 fallCnt_r;

    logic                       readback;
    logic [4:0]                 relLimit;
    logic                       released;
    logic [ACR_FRAME_W-1:0]     frameWord;

    //////////////////////////////////////////////////////////////////////////////////////
    // Crossings into the system clock domain

    acr_sync #(
        .WIDTH (3)
    ) u_sync (
        .clk     (ref_clk),
        .reset_n (reset_n),
        .clkEn   (clkEn),
        .asyncIn ({convertStrobe, cfgTgl_r, released}),
        .syncOut ({strobeSync, cfgTglSync, releasedSync})
    );

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            strobePrev_r <= 1'b0;
            cfgTglSeen_r <= 1'b0;
        end else if (clkEn) begin
            strobePrev_r <= strobeSync;
            cfgTglSeen_r <= cfgTglSync;
        end
    end

    assign cfgEvt   = cfgTglSync ^ cfgTglSeen_r;
    // Rising edges during a conversion are ignored: the state is not idle
    assign startEvt = (state_r == ACR_IDLE) && strobeSync && !strobePrev_r;
    assign convDone = (state_r == ACR_CONVERT) &&
                      (convTimer_r == ACR_TIMER_W'(CONV_CYCLES - 1));

    //////////////////////////////////////////////////////////////////////////////////////
    // Conversion sequencing

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r     <= ACR_IDLE;
            convTimer_r <= '0;
        end else if (clkEn) begin
            unique case (state_r)
                ACR_IDLE: begin
                    convTimer_r <= '0;
                    if (startEvt) begin
                        state_r <= ACR_CONVERT;
                    end
                end
                ACR_CONVERT: begin
                    // Strobe level is not looked at until the timer expires
                    if (convDone) begin
                        state_r <= ACR_IDLE;
                    end else begin
                        convTimer_r <= convTimer_r + 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            convStart <= 1'b0;
            convEnd   <= 1'b0;
        end else if (clkEn) begin
            convStart <= startEvt;
            convEnd   <= convDone;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Configuration pipeline: pending word, word in use, word tied to the result

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pendingCfg_r   <= '0;
            pendingValid_r <= 1'b0;
            activeCfg      <= CFG_RESET;
            resultCfg_r    <= CFG_RESET;
        end else if (clkEn) begin
            if (convDone) begin
                resultCfg_r <= activeCfg;
                if (pendingValid_r) begin
                    activeCfg <= pendingCfg_r;
                end
            end
            // Only complete words raise an event, so partial ones never land here
            if (cfgEvt) begin
                pendingCfg_r   <= cfgHold_r;
                pendingValid_r <= 1'b1;
            end else if (convDone) begin
                pendingValid_r <= 1'b0;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Result capture and output mode

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            resultWord_r <= '0;
            busyMode_r   <= 1'b0;
            dataReady_r  <= 1'b0;
            holdLast_r   <= 1'b0;
            lastBit_r    <= 1'b0;
        end else if (clkEn) begin
            if (convDone) begin
                resultWord_r <= sampleResult;
                // Strobe low at conversion end selects the busy indicator
                busyMode_r   <= !strobeSync;
                dataReady_r  <= 1'b1;
                holdLast_r   <= 1'b0;
            end else if (startEvt) begin
                dataReady_r <= 1'b0;
                // Busy frame never released: keep its last bit until next end
                holdLast_r  <= busyMode_r && dataReady_r && !releasedSync;
                lastBit_r   <= serialResultOut;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Link domain: edge counters cleared while the strobe is high

    assign linkRst = convertStrobe || !reset_n;

    always_ff @(posedge serialClk or posedge linkRst) begin
        if (linkRst) begin
            riseCnt_r  <= '0;
            cfgFull_r  <= 1'b0;
            cfgShift_r <= '0;
        end else begin
            if (!cfgFull_r) begin
                cfgShift_r <= {cfgShift_r[ACR_CFG_W-3:0], serialCfgIn};
                if (riseCnt_r == ACR_CFG_LAST_EDGE) begin
                    cfgFull_r <= 1'b1;
                end else begin
                    riseCnt_r <= riseCnt_r + 1'b1;
                end
            end else if (serialCfgIn) begin
                // A high bit after a complete word opens a fresh word
                cfgFull_r  <= 1'b0;
                riseCnt_r  <= 4'h1;
                cfgShift_r <= {{(ACR_CFG_W-2){1'b0}}, serialCfgIn};
            end
        end
    end

    // Kept out of the strobe reset so that a strobe edge never fakes an event
    always_ff @(posedge serialClk or negedge reset_n) begin
        if (!reset_n) begin
            cfgHold_r <= '0;
            cfgTgl_r  <= 1'b0;
        end else if (!convertStrobe && !cfgFull_r && riseCnt_r == ACR_CFG_LAST_EDGE) begin
            cfgHold_r <= {cfgShift_r, serialCfgIn};
            cfgTgl_r  <= !cfgTgl_r;
        end
    end

    always_ff @(negedge serialClk or posedge linkRst) begin
        if (linkRst) begin
            fallCnt_r <= '0;
        end else if (fallCnt_r != ACR_FALL_MAX) begin
            fallCnt_r <= fallCnt_r + 1'b1;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Data output

    assign readback = !resultCfg_r[ACR_CFG_NO_RB_BIT];
    assign frameWord = readback ? {resultWord_r, resultCfg_r}
                                : {resultWord_r, {ACR_CFG_W{1'b0}}};

    always_comb begin
        if (busyMode_r) begin
            relLimit = readback ? ACR_REL_BUSY_RB : ACR_REL_BUSY;
        end else begin
            relLimit = readback ? ACR_REL_PLAIN_RB : ACR_REL_PLAIN;
        end
    end

    assign released = fallCnt_r >= relLimit;

    // Bit only changes on a falling edge, so it holds across the rising one
    always_comb begin
        logic [4:0] pos;
        pos = '0;
        serialResultOut = 1'b0;
        if (holdLast_r) begin
            serialResultOut = lastBit_r;
        end else if (busyMode_r) begin
            // Low before the first falling edge marks data ready
            if (fallCnt_r != 5'h00 && !released) begin
                pos = fallCnt_r - 5'h01;
                serialResultOut = frameWord[5'(ACR_FRAME_W - 1) - pos];
            end else if (fallCnt_r != 5'h00) begin
                serialResultOut = frameWord[0];
            end
        end else if (!released) begin
            pos = fallCnt_r;
            serialResultOut = frameWord[5'(ACR_FRAME_W - 1) - pos];
        end
    end

    always_comb begin
        serialResultOutEn = 1'b0;
        if (holdLast_r) begin
            serialResultOutEn = 1'b1;
        end else if (busyMode_r) begin
            serialResultOutEn = dataReady_r && !released;
        end else begin
            serialResultOutEn = dataReady_r && !strobeSync && !released;
        end
    end

endmodule

`default_nettype wire

// File: core/acr_serial_convert_fix.sv
// Intentionally holds no module
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: tb/acr_serial_convert_checker.sv
// Port assertions for the converter serial interface
`timescale 1ns/1ps
`default_nettype none

module acr_serial_convert_checker
    import acr_pkg::*;
#(
    parameter int CONV_CYCLES = ACR_CONV_CYCLES
) (
    input wire logic                 ref_clk,
    input wire logic                 reset_n,
    input wire logic                 clkEn,
    input wire logic                 serialClk,
    input wire logic                 convertStrobe,
    input wire logic                 serialCfgIn,
    input wire logic                 serialResultOut,
    input wire logic                 serialResultOutEn,
    input wire logic                 convStart,
    input wire logic                 convEnd,
    input wire logic [ACR_CFG_W-1:0] activeCfg,
    input wire logic [ACR_RES_W-1:0] sampleResult
);
    logic [7:0] convCnt_r;
    logic       plainReady_r;
    logic       resMsb_r;

    // Cycles since the start pulse
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) convCnt_r <= 8'h00;
        else if (!clkEn) convCnt_r <= convCnt_r;
        else if (convStart) convCnt_r <= 8'h01;
        else if (convCnt_r != 8'h00 && convCnt_r < 8'(CONV_CYCLES)) convCnt_r <= convCnt_r + 8'h01;
        else convCnt_r <= 8'h00;
    end

    // Raw strobe level at the end, not the synced one: the bench keeps it steady there
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) plainReady_r <= 1'b0;
        else if (convStart) plainReady_r <= 1'b0;
        else if (convEnd) plainReady_r <= convertStrobe;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) resMsb_r <= 1'b0;
        else if (convCnt_r == 8'(CONV_CYCLES - 1)) resMsb_r <= sampleResult[ACR_RES_W-1];
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    AST_END_TIMED: assert property (convEnd |-> convCnt_r == 8'(CONV_CYCLES))
        else $error("conversion end off its cycle");
    AST_CONV_RUNS: assert property (convCnt_r == 8'(CONV_CYCLES) |-> convEnd)
        else $error("conversion did not complete");
    AST_START_QUIET: assert property (convStart |-> convCnt_r == 8'h00)
        else $error("restart inside a conversion");
    AST_START_SEEN: assert property ($rose(convertStrobe) && convCnt_r == 8'h00 |-> ##[1:4] convStart)
        else $error("strobe rise did not start a conversion");
    AST_NO_DRIVE_IN_CONV: assert property ((convCnt_r != 8'h00 && convCnt_r < 8'(CONV_CYCLES - 1)) |-> !$rose(serialResultOutEn))
        else $error("output enabled during conversion");
    AST_BUSY_LOW: assert property ((!convertStrobe)[*4] ##0 convEnd |-> ##[0:2] (serialResultOutEn && !serialResultOut))
        else $error("no low data-ready level");
    AST_PLAIN_MSB: assert property (plainReady_r && $fell(convertStrobe) |-> ##[1:4] (serialResultOutEn && serialResultOut == resMsb_r))
        else $error("result top bit not driven");
    AST_PLAIN_FLOAT: assert property ((plainReady_r && convertStrobe)[*4] |-> !serialResultOutEn)
        else $error("output driven while strobe high");
    AST_CFG_AT_END: assert property ($changed(activeCfg) |-> (convEnd || $past(convEnd)))
        else $error("configuration changed away from conversion end");

    CVR_PLAIN: cover property (convEnd && convertStrobe);
    CVR_BUSY: cover property (convEnd && !convertStrobe);
    CVR_CFG: cover property ($changed(activeCfg));
endmodule

`default_nettype wire

// File: tb/acr_host_model.sv
// Host side: strobe, serial clock and configuration data
`timescale 1ns/1ps
`default_nettype none

module acr_host_model (
    input  wire logic ref_clk,
    input  wire logic pinLevel,
    output var logic  convertStrobe,
    output var logic  serialClk,
    output var logic  serialCfgIn
);
    initial begin
        convertStrobe = 1'b0;
        serialClk     = 1'b0;
        serialCfgIn   = 1'b0;
    end

    // Strobe level chooses busy or plain mode at conversion end
    task automatic set_strobe(input logic lvl);
        @(posedge ref_clk);
        convertStrobe <= lvl;
    endtask

    // Only called while the strobe is high, where edges are ignored
    task automatic set_idle(input logic lvl);
        serialClk = lvl;
    endtask

    // Clock stands still outside frames; capture on rising edges
    task automatic frame(input int n, input logic cpol, input logic [13:0] word,
                         input int nw, output logic [31:0] rd);
        rd = 32'h0;
        for (int i = 0; i < n; i++) begin
            if (cpol) serialClk = 1'b0;
            serialCfgIn = (i < nw) ? word[13 - i] : 1'b0;
            #24;
            serialClk = 1'b1;
            rd = {rd[30:0], pinLevel};
            #24;
            if (!cpol) serialClk = 1'b0;
        end
        serialCfgIn = 1'b0;
    endtask
endmodule

`default_nettype wire

// File: tb/adc_serial_convert_config_readback_test.sv
// Testbench for the converter serial interface
`timescale 1ns/1ps
`default_nettype none

module adc_serial_convert_config_readback_test;
    import acr_pkg::*;
    localparam int          CONV  = 20;
    localparam logic [13:0] CFG_W = 14'h2a54;
    logic                 ref_clk, reset_n, clkEn, convertStrobe, serialClk, serialCfgIn;
    logic                 serialResultOut, serialResultOutEn, convStart, convEnd;
    logic [ACR_CFG_W-1:0] activeCfg;
    logic [ACR_RES_W-1:0] sampleResult;
    logic [31:0]          rd;
    wire logic            pinLevel;
    int                   num_errors = 0;
    int                   checks_done = 0;

    // Pull-up on the data line
    assign pinLevel = serialResultOutEn ? serialResultOut : 1'b1;

    acr_serial_convert #(.CONV_CYCLES(CONV)) dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .clkEn(clkEn), .serialClk(serialClk),
        .convertStrobe(convertStrobe), .serialCfgIn(serialCfgIn),
        .serialResultOut(serialResultOut), .serialResultOutEn(serialResultOutEn),
        .convStart(convStart), .convEnd(convEnd), .activeCfg(activeCfg),
        .sampleResult(sampleResult));
    acr_host_model host (.ref_clk(ref_clk), .pinLevel(pinLevel), .convertStrobe(convertStrobe),
        .serialClk(serialClk), .serialCfgIn(serialCfgIn));

    initial ref_clk = 1'b0;
    always #20 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Strobe low, then a rise; it stays high or drops early
    task automatic convert(input logic [13:0] res, input logic holdHigh);
        int k;
        host.set_strobe(1'b0);
        cycles(3);
        sampleResult <= res;
        host.set_strobe(1'b1);
        cycles(4);
        if (!holdHigh) host.set_strobe(1'b0);
        check(serialResultOutEn, 1'b0);
        k = 0;
        while (convEnd !== 1'b1 && k < 200) begin
            cycles(1);
            k++;
        end
        if (k == 200) begin
            num_errors++;
            finish_test();
        end
    endtask

    task automatic test_plain();
        convert(14'h2d71, 1'b1);
        host.set_strobe(1'b0);
        cycles(4);
        check({serialResultOutEn, serialResultOut}, 2'h3);
        host.frame(14, 1'b0, CFG_W, 14, rd);
        check(rd[13:0], 14'h2d71);
        cycles(2);
        check(serialResultOutEn, 1'b0);
        check(activeCfg, ACR_CFG_RESET);
        $display("test_plain done");
    endtask

    task automatic test_readback();
        convert(14'h1a3c, 1'b1);
        check(activeCfg, CFG_W);
        convert(14'h0e96, 1'b1);
        host.set_strobe(1'b0);
        cycles(4);
        host.frame(28, 1'b0, CFG_W, 14, rd);
        check(rd[27:0], {14'h0e96, CFG_W});
        cycles(2);
        check(serialResultOutEn, 1'b0);
        $display("test_readback done");
    endtask

    // Ten edges only, then the strobe rise cuts the frame
    task automatic test_short();
        convert(14'h3333, 1'b1);
        host.set_strobe(1'b0);
        cycles(4);
        host.frame(10, 1'b0, 14'h3ffd, 10, rd);
        check(rd[9:0], 10'h333);
        host.set_strobe(1'b1);
        cycles(4);
        check(serialResultOutEn, 1'b0);
        convert(14'h0101, 1'b1);
        convert(14'h0202, 1'b1);
        check(activeCfg, CFG_W);
        $display("test_short done");
    endtask

    task automatic test_busy();
        host.set_idle(1'b1);
        convert(14'h2b4e, 1'b0);
        cycles(2);
        check({serialResultOutEn, serialResultOut}, 2'h2);
        host.frame(29, 1'b1, 14'h0, 0, rd);
        check(rd[28:0], {14'h2b4e, CFG_W, 1'b1});
        check(serialResultOutEn, 1'b0);
        host.set_strobe(1'b1);
        cycles(3);
        host.set_idle(1'b0);
        $display("test_busy done");
    endtask

    // Clock enable low must freeze a running conversion
    task automatic test_freeze();
        int k;
        cycles(30);
        host.set_strobe(1'b0);
        cycles(3);
        host.set_strobe(1'b1);
        cycles(4);
        @(posedge ref_clk);
        clkEn <= 1'b0;
        k = 0;
        repeat (2 * CONV) begin
            cycles(1);
            if (convEnd === 1'b1) k++;
        end
        check(k, 0);
        @(posedge ref_clk);
        clkEn <= 1'b1;
        k = 0;
        while (convEnd !== 1'b1 && k < CONV) begin
            cycles(1);
            k++;
        end
        check(k < CONV, 1'b1);
        $display("test_freeze done");
    endtask

    initial begin
        reset_n      = 1'b0;
        clkEn        = 1'b1;
        sampleResult = 14'h0;
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
        cycles(2);
        test_plain();
        test_readback();
        test_short();
        test_busy();
        test_freeze();
        finish_test();
    end
endmodule

bind acr_serial_convert acr_serial_convert_checker #(.CONV_CYCLES(CONV_CYCLES)) chk (
    .ref_clk(ref_clk), .reset_n(reset_n), .clkEn(clkEn), .serialClk(serialClk),
    .convertStrobe(convertStrobe), .serialCfgIn(serialCfgIn),
    .serialResultOut(serialResultOut), .serialResultOutEn(serialResultOutEn),
    .convStart(convStart), .convEnd(convEnd), .activeCfg(activeCfg),
    .sampleResult(sampleResult));

`default_nettype wire
